//--- shared/route_rewrite_pkg.sv
// Constants and types shared by the source-route frame rewriter.
`default_nettype none
package route_rewrite_pkg;

  localparam int unsigned WORD_W    = 16;
  localparam int unsigned ADDR_W    = 9;
  localparam int unsigned PTR_W     = 10;
  localparam logic [PTR_W-1:0] MAX_WORDS = 10'h200;

  // Word positions inside a stored frame.
  localparam logic [PTR_W-1:0] DA_WORDS  = 10'h003;
  localparam logic [PTR_W-1:0] DA_W1_IDX = 10'h001;
  localparam logic [PTR_W-1:0] DA_W2_IDX = 10'h002;
  localparam logic [PTR_W-1:0] SA_HI_IDX = 10'h003;
  localparam logic [PTR_W-1:0] RC_IDX    = 10'h006;
  localparam logic [PTR_W-1:0] RIF_IDX   = 10'h007;

  // Field positions.
  localparam int unsigned RII_BIT     = 15;
  localparam int unsigned RC_LEN_HI   = 12;
  localparam int unsigned RC_LEN_LO   = 8;
  localparam logic [4:0]  RC_HDR_BYTES = 5'h02;
  localparam logic [3:0]  SINGLE_MAX  = 4'h3;

  // Vendor group destination address, upper 32 bits, and the group LAN.
  localparam logic [15:0] GRP_DA_W0 = 16'hC000;
  localparam logic [15:0] GRP_DA_W1 = 16'hA2FF;
  localparam logic [11:0] GRP_LAN   = 12'hFFF;

  // Reset value and the number of saved destination address words.
  localparam logic [3:0]  NIBBLE_RST = 4'h0;
  localparam logic [1:0]  SAVE_WORDS = 2'h3;

  typedef enum logic [1:0] {
    ROLE_PASS,
    ROLE_FIRST,
    ROLE_MIDDLE,
    ROLE_LAST
  } role_e;

endpackage
`default_nettype wire

//--- src/route_parser.sv
// Streaming parser that classifies a frame and finds its route designators.
`timescale 1ns/10ps
`default_nettype none
module route_parser
  import route_rewrite_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              word_valid,
  input  wire logic [PTR_W-1:0]  word_idx,
  input  wire logic [WORD_W-1:0] word_data,
  input  wire logic [11:0]       own_lan_id,
  input  wire logic [11:0]       out_lan_id,
  output role_e                  role,
  output logic [3:0]             next_bridge,
  output logic [3:0]             own_idx,
  output logic [3:0]             desig_cnt
);

  logic       da_group;
  logic       routing_info_indicator;
  logic       last_out;
  logic [4:0] rc_bytes;
  logic [3:0] k;
  logic       in_rif;

  assign rc_bytes = word_data[RC_LEN_HI:RC_LEN_LO];
  assign k        = 4'(word_idx - RIF_IDX);
  assign in_rif   = (word_idx >= RIF_IDX) && (word_idx < RIF_IDX + PTR_W'(desig_cnt));

  // Group destination address detection over the first three words.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      da_group <= 1'b0;
    end else if (word_valid) begin
      if (word_idx == '0) begin
        da_group <= (word_data == GRP_DA_W0);
      end else if (word_idx == DA_W1_IDX) begin
        da_group <= da_group && (word_data == GRP_DA_W1);
      end else if (word_idx == DA_W2_IDX) begin
        da_group <= da_group && (word_data[15:4] == GRP_LAN);
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      routing_info_indicator <= 1'b0;
    end else if (word_valid && word_idx == '0) begin
      routing_info_indicator <= 1'b0;
    end else if (word_valid && word_idx == SA_HI_IDX) begin
      routing_info_indicator <= word_data[RII_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      desig_cnt <= NIBBLE_RST;
    end else if (word_valid && word_idx == '0) begin
      desig_cnt <= NIBBLE_RST;
    end else if (word_valid && word_idx == RC_IDX) begin
      desig_cnt <= (rc_bytes < RC_HDR_BYTES) ? NIBBLE_RST : 4'((rc_bytes - RC_HDR_BYTES) >> 1);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      own_idx     <= '1;
      next_bridge <= NIBBLE_RST;
      last_out    <= 1'b0;
    end else if (word_valid && word_idx == '0) begin
      own_idx     <= '1;
      next_bridge <= NIBBLE_RST;
      last_out    <= 1'b0;
    end else if (word_valid && in_rif) begin
      if (word_data[15:4] == own_lan_id) begin
        own_idx <= k;
      end
      // The designator of the outgoing ring names the next bridge.
      if (word_data[15:4] == out_lan_id) begin
        next_bridge <= word_data[3:0];
      end
      if (k == desig_cnt - 4'h1) begin
        last_out <= (word_data[15:4] == out_lan_id);
      end
    end
  end

  always_comb begin
    if (!routing_info_indicator || desig_cnt <= SINGLE_MAX) begin
      role = ROLE_PASS;
    end else if (!da_group) begin
      role = ROLE_FIRST;
    end else if (last_out) begin
      role = ROLE_LAST;
    end else begin
      role = ROLE_MIDDLE;
    end
  end

endmodule
`default_nettype wire

//--- src/source_route_frame_rewriter.sv
// Store-and-forward rewriter for specifically routed frames crossing a bridge chain.
`timescale 1ns/10ps
`default_nettype none
module source_route_frame_rewriter
  import route_rewrite_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic [11:0]       own_lan_id,
  input  wire logic [3:0]        own_bridge_id,
  input  wire logic [11:0]       out_lan_id,
  input  wire logic              in_valid,
  input  wire logic [WORD_W-1:0] in_data,
  input  wire logic              in_last,
  output logic                   in_ready,
  output logic                   out_valid,
  output logic [WORD_W-1:0]      out_data,
  output logic                   out_last,
  input  wire logic              out_ready,
  output role_e                  frame_role
);

  typedef enum logic {ST_RECV, ST_EMIT} state_e;

  logic [WORD_W-1:0] mem [0:(1<<ADDR_W)-1];
  state_e            state;
  state_e            next_state;
  logic [PTR_W-1:0]  wr_cnt;
  logic [PTR_W-1:0]  rp;
  logic [1:0]        sv;
  logic              ins_done;
  role_e             role;
  logic [3:0]        next_bridge;
  logic [3:0]        own_idx;
  logic [3:0]        desig_cnt;
  logic              in_fire;
  logic              slot;
  logic [PTR_W-1:0]  end_rp;
  logic [3:0]        k;
  logic [WORD_W-1:0] rd_word;
  logic [WORD_W-1:0] next_word;
  logic              next_have;
  logic              next_last;
  logic              adv_rp;
  logic              adv_sv;
  logic              set_ins;
  logic              done;

  function automatic logic [WORD_W-1:0] group_da(input logic [PTR_W-1:0] idx, input logic [3:0] id);
    if (idx == '0) begin
      return GRP_DA_W0;
    end else if (idx == DA_W1_IDX) begin
      return GRP_DA_W1;
    end
    return {GRP_LAN, id};
  endfunction

  assign in_fire = in_valid && in_ready;
  assign slot    = !out_valid || out_ready;
  assign k       = 4'(rp - RIF_IDX);
  assign rd_word = mem[rp[ADDR_W-1:0]];

  assign end_rp = (role == ROLE_LAST && wr_cnt >= DA_WORDS) ? wr_cnt - DA_WORDS : wr_cnt;

  route_parser u_parser (
    .core_clk    (core_clk),
    .rst_n       (rst_n),
    .word_valid  (in_fire),
    .word_idx    (wr_cnt),
    .word_data   (in_data),
    .own_lan_id  (own_lan_id),
    .out_lan_id  (out_lan_id),
    .role        (role),
    .next_bridge (next_bridge),
    .own_idx     (own_idx),
    .desig_cnt   (desig_cnt)
  );

  always_ff @(posedge core_clk) begin
    if (in_fire && wr_cnt < MAX_WORDS) begin
      mem[wr_cnt[ADDR_W-1:0]] <= in_data;
    end
  end

  always_comb begin
    next_word = rd_word;
    next_have = 1'b0;
    next_last = 1'b0;
    adv_rp    = 1'b0;
    adv_sv    = 1'b0;
    set_ins   = 1'b0;
    if (rp < end_rp) begin
      next_have = 1'b1;
      adv_rp    = 1'b1;
      if (rp < DA_WORDS) begin
        if (role == ROLE_FIRST) begin
          next_word = group_da(rp, next_bridge);
        end else if (role == ROLE_MIDDLE && rp == DA_W2_IDX) begin
          next_word = {rd_word[15:4], next_bridge};
        end else if (role == ROLE_LAST) begin
          next_word = mem[ADDR_W'(end_rp + rp)];
        end
      end else if (rp >= RIF_IDX && k < desig_cnt) begin
        if (role == ROLE_FIRST && k == desig_cnt - 4'h1 && !ins_done) begin
          next_word = {GRP_LAN, next_bridge};
          adv_rp    = 1'b0;
          set_ins   = 1'b1;
        end else if (role == ROLE_FIRST && k == own_idx) begin
          next_have = 1'b0;
        end else if (role == ROLE_LAST && rd_word[15:4] == GRP_LAN) begin
          next_word = {own_lan_id, own_bridge_id};
        end
      end
      next_last = (role != ROLE_FIRST) && adv_rp && (rp == end_rp - 10'h001);
    end else if (role == ROLE_FIRST && sv < SAVE_WORDS) begin
      next_have = 1'b1;
      adv_sv    = 1'b1;
      next_word = mem[ADDR_W'(sv)];
      next_last = (sv == SAVE_WORDS - 2'h1);
    end
  end

  assign done = (rp >= end_rp) && !(role == ROLE_FIRST && sv < SAVE_WORDS);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RECV: begin
        if (in_fire && in_last) begin
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        if (slot && (done || (next_have && next_last))) begin
          next_state = ST_RECV;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state    <= ST_RECV;
      in_ready <= 1'b1;
    end else begin
      state    <= next_state;
      in_ready <= (next_state == ST_RECV);
    end
  end

  // Words past the store depth are dropped; the frame is cut to that length.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_cnt <= '0;
    end else if (state == ST_EMIT && next_state == ST_RECV) begin
      wr_cnt <= '0;
    end else if (in_fire && wr_cnt < MAX_WORDS) begin
      wr_cnt <= wr_cnt + 10'h001;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rp       <= '0;
      sv       <= '0;
      ins_done <= 1'b0;
    end else if (state == ST_RECV) begin
      rp       <= '0;
      sv       <= '0;
      ins_done <= 1'b0;
    end else if (slot) begin
      if (adv_rp) begin
        rp <= rp + 10'h001;
      end
      if (adv_sv) begin
        sv <= sv + 2'h1;
      end
      if (set_ins) begin
        ins_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data  <= '0;
      out_last  <= 1'b0;
    end else if (slot) begin
      out_valid <= (state == ST_EMIT) && next_have;
      out_data  <= next_word;
      out_last  <= (state == ST_EMIT) && next_have && next_last;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_role <= ROLE_PASS;
    end else if (state == ST_RECV && next_state == ST_EMIT) begin
      frame_role <= role;
    end
  end

endmodule
`default_nettype wire

//--- sim/frame_rewriter_checker.sv
// Port checks for the source-route frame rewriter.
`timescale 1ns/10ps
`default_nettype none
module frame_rewriter_checker
  import route_rewrite_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        in_valid,
  input wire logic [15:0] in_data,
  input wire logic        in_last,
  input wire logic        in_ready,
  input wire logic        out_valid,
  input wire logic [15:0] out_data,
  input wire logic        out_last,
  input wire logic        out_ready,
  input wire role_e       frame_role
);
  logic [9:0]  iidx;
  logic [9:0]  oidx;
  logic        src_rt;
  logic [15:0] rc;
  wire         take_in  = in_valid && in_ready;
  wire         take_end = take_in && in_last;
  wire         grp_role = frame_role inside {ROLE_FIRST, ROLE_MIDDLE};

  // Track word positions so checks can name a field of the frame.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      iidx   <= '0;
      oidx   <= '0;
      src_rt <= 1'b0;
      rc     <= '0;
    end else begin
      if (take_in) iidx <= in_last ? 10'h000 : iidx + 10'h001;
      if (take_in && iidx == 10'h003) src_rt <= in_data[15];
      if (take_in && iidx == 10'h006) rc <= in_data;
      if (out_valid && out_ready) oidx <= out_last ? 10'h000 : oidx + 10'h001;
    end
  end

  default clocking dc @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data) && $stable(out_last))
    else $error("stalled word changed");
  ready_drop_a: assert property (take_end |=> !in_ready)
    else $error("input open during emission");
  // The state register and then the output register each take one edge.
  out_start_a: assert property (take_end && !out_valid |-> ##2 out_valid)
    else $error("emission late");
  plain_role_a: assert property (take_end && !src_rt |=> frame_role == ROLE_PASS)
    else $error("transparent frame rewritten");
  single_pass_a: assert property (take_end && rc[12:8] <= 5'h08 |=> frame_role == ROLE_PASS)
    else $error("one-bridge frame rewritten");
  grp_head_a: assert property (out_valid && grp_role && oidx < 10'h002 |->
    out_data == (oidx == 10'h000 ? GRP_DA_W0 : GRP_DA_W1))
    else $error("group address head wrong");
  grp_tail_a: assert property (out_valid && grp_role && oidx == 10'h002 |-> out_data[15:4] == GRP_LAN)
    else $error("group address tail wrong");
  rif_len_a: assert property (out_valid && oidx == 10'h006 |-> out_data == rc)
    else $error("route control changed");
  ready_back_a: assert property ($rose(out_valid && out_last) |-> in_ready)
    else $error("input not reopened");

  cover property (out_valid && frame_role == ROLE_FIRST);
  cover property (out_valid && frame_role == ROLE_MIDDLE);
  cover property (out_valid && frame_role == ROLE_LAST);
endmodule

bind source_route_frame_rewriter frame_rewriter_checker chk (
  .core_clk(core_clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
  .in_ready(in_ready), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
  .out_ready(out_ready), .frame_role(frame_role));
`default_nettype wire

//--- sim/frame_sink.sv
// Receiving station model that takes rewritten words, optionally stalling every other cycle.
`timescale 1ns/10ps
`default_nettype none
module frame_sink (
  input  wire logic        core_clk,
  input  wire logic        out_valid,
  input  wire logic [15:0] out_data,
  input  wire logic        out_last,
  input  wire logic        slow,
  output var  logic        out_ready
);
  logic [16:0] got[$];
  int          frames;

  initial begin
    out_ready = 1'b1;
    frames    = 0;
  end

  always @(posedge core_clk) begin
    if (out_valid && out_ready) begin
      got.push_back({out_last, out_data});
      if (out_last) frames++;
    end
    #1 out_ready = slow ? !out_ready : 1'b1;
  end
endmodule
`default_nettype wire

//--- sim/source_route_frame_rewriter_bench.sv
// Self-checking bench for the source-route frame rewriter.
`timescale 1ns/10ps
`default_nettype none
module source_route_frame_rewriter_bench;
  import route_rewrite_pkg::*;
  typedef logic [15:0] word_t;
  typedef word_t wq_t[$];
  typedef struct {
    logic [11:0] own;
    logic [3:0]  bid;
    logic [11:0] outl;
    logic        src_rt;
    int          n;
    logic [47:0] da;
    logic [79:0] ds;
    logic        tail;
    logic [47:0] eda;
    logic [79:0] eds;
    logic        etail;
    role_e       role;
  } row_s;
  localparam logic [47:0] STA = 48'h4000_0000_0002;
  localparam logic [47:0] GRA = 48'hC000_A2FF_FFFA;
  localparam logic [79:0] RT  = 80'h001A_100A_002A_003A_0040;
  localparam logic [79:0] GRT = 80'h001A_002A_003A_FFFA_0040;
  localparam logic [79:0] GRB = 80'h001A_002A_003B_FFFA_0040;
  row_s rows[6] = '{
    '{12'h100, 4'hA, 12'h002, 1'b0, 5, STA, RT, 1'b0, STA, RT, 1'b0, ROLE_PASS},
    '{12'h100, 4'hA, 12'h002, 1'b1, 3, STA, RT, 1'b0, STA, RT, 1'b0, ROLE_PASS},
    '{12'h100, 4'hA, 12'h002, 1'b1, 5, STA, RT, 1'b0, GRA, GRT, 1'b1, ROLE_FIRST},
    '{12'h200, 4'hA, 12'h003, 1'b1, 5, GRA, GRB, 1'b1, 48'hC000_A2FF_FFFB, GRB, 1'b1, ROLE_MIDDLE},
    '{12'h200, 4'hA, 12'h003, 1'b1, 5, GRA, GRT, 1'b1, GRA, GRT, 1'b1, ROLE_MIDDLE},
    '{12'h102, 4'h7, 12'h004, 1'b1, 5, GRA, GRT, 1'b1, STA, 80'h001A_002A_003A_1027_0040, 1'b0, ROLE_LAST}
  };
  logic        core_clk;
  logic        rst_n;
  logic [11:0] own_lan_id;
  logic [3:0]  own_bridge_id;
  logic [11:0] out_lan_id;
  logic        in_valid;
  word_t       in_data;
  logic        in_last;
  logic        in_ready;
  logic        out_valid;
  word_t       out_data;
  logic        out_last;
  logic        out_ready;
  logic        slow;
  role_e       frame_role;
  int          mismatches;
  int          checks;
  logic [16:0] fexp[$];

  source_route_frame_rewriter dut (
    .core_clk(core_clk), .rst_n(rst_n), .own_lan_id(own_lan_id), .own_bridge_id(own_bridge_id),
    .out_lan_id(out_lan_id), .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .frame_role(frame_role));
  frame_sink sink (.core_clk(core_clk), .out_valid(out_valid), .out_data(out_data), .out_last(out_last),
    .slow(slow), .out_ready(out_ready));

  task automatic check(input logic [23:0] seen, input logic [23:0] want);
    checks++;
    if (seen !== want) begin
      mismatches++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    if (mismatches == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  function automatic wq_t frame(input logic rt, input int n, input logic [47:0] da, input logic [79:0] ds,
                                input logic tail);
    wq_t q;
    for (int i = 0; i < 3; i++) q.push_back(da[47-16*i -: 16]);
    q.push_back({rt, 15'h0000});
    q.push_back(16'h0000);
    q.push_back(16'h0001);
    q.push_back({3'h0, 5'(2 + 2 * n), 8'h30});
    for (int i = 0; i < n; i++) q.push_back(ds[79-16*i -: 16]);
    q.push_back(16'h0404);
    q.push_back(16'h1234);
    if (tail) for (int i = 0; i < 3; i++) q.push_back(STA[47-16*i -: 16]);
    return q;
  endfunction

  task automatic send(input wq_t q);
    logic ok;
    // Let one edge pass so valid is never lowered and raised in the same time step.
    @(posedge core_clk);
    #1;
    foreach (q[i]) begin
      in_valid = 1'b1;
      in_data  = q[i];
      in_last  = (i == q.size() - 1);
      do begin
        @(negedge core_clk) ok = in_ready;
        @(posedge core_clk);
      end while (ok !== 1'b1);
      #1;
    end
    in_valid = 1'b0;
    in_last  = 1'b0;
  endtask

  // Plays cnt rows from row a back to back under the settings of row a.
  task automatic play(input int a, input int cnt);
    wq_t e;
    int  n;
    own_lan_id    = rows[a].own;
    own_bridge_id = rows[a].bid;
    out_lan_id    = rows[a].outl;
    n = sink.frames + cnt;
    sink.got.delete();
    for (int k = a; k < a + cnt; k++) begin
      send(frame(rows[k].src_rt, rows[k].n, rows[k].da, rows[k].ds, rows[k].tail));
      check(frame_role, rows[k].role);
      e = frame(rows[k].src_rt, rows[k].n, rows[k].eda, rows[k].eds, rows[k].etail);
      foreach (e[i]) fexp.push_back({i == e.size() - 1, e[i]});
    end
    for (int t = 0; t < 4000 && sink.frames < n; t++) @(posedge core_clk);
    #1;
    check(sink.got.size(), fexp.size());
    foreach (fexp[i]) check(sink.got[i], fexp[i]);
    fexp.delete();
  endtask

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  initial begin
    #200000;
    mismatches++;
    stop_test();
  end

  initial begin
    mismatches    = 0;
    checks        = 0;
    rst_n         = 1'b0;
    slow          = 1'b0;
    in_valid      = 1'b0;
    in_data       = '0;
    in_last       = 1'b0;
    own_lan_id    = '0;
    own_bridge_id = '0;
    out_lan_id    = '0;
    repeat (4) @(posedge core_clk);
    #1;
    check({in_ready, out_valid, out_last, frame_role, out_data}, 24'h100000);
    rst_n = 1'b1;
    foreach (rows[k]) begin
      slow = k[0];
      play(k, 1);
    end
    play(0, 3);
    slow = 1'b1;
    send(frame(1'b1, 5, STA, RT, 1'b0));
    repeat (3) @(posedge core_clk);
    #1 rst_n = 1'b0;
    #1 check({in_ready, out_valid, out_last, frame_role, out_data}, 24'h100000);
    @(posedge core_clk);
    #1 rst_n = 1'b1;
    play(5, 1);
    stop_test();
  end
endmodule
`default_nettype wire
